// [rtl/tccb_defs.vh]
`ifndef TCCB_DEFS_VH
`define TCCB_DEFS_VH

// channel count and data widths
`define TCCB_NCH 7
`define TCCB_TW 16

// edge_mode_bits encodings
`define TCCB_EDGE_NONE 2'h0
`define TCCB_EDGE_RISE 2'h1
`define TCCB_EDGE_FALL 2'h2
`define TCCB_EDGE_BOTH 2'h3

// input_select encodings (input_select_high, input_select_low)
`define TCCB_SEL_A 2'h0
`define TCCB_SEL_B 2'h1
`define TCCB_SEL_GND 2'h2
`define TCCB_SEL_VCC 2'h3

// latch_load_select encodings
`define TCCB_LOAD_IMM 2'h0
`define TCCB_LOAD_ZERO 2'h1
`define TCCB_LOAD_ZERO_TOP 2'h2
`define TCCB_LOAD_OWN 2'h3

// reset values
`define TCCB_CCR_RST 16'h0000
`define TCCB_LATCH_RST 16'h0000

`endif

// [rtl/tccb_capsel.v]
`timescale 1ns/1ns
`include "tccb_defs.vh"

module tccb_capsel (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // capture sources from pins
  input wire capture_input_a_i,
  input wire capture_input_b_i,
  // channel configuration
  input wire [1:0] input_select_i,
  input wire sync_capture_select_i,
  input wire [1:0] edge_mode_bits_i,
  // results
  output reg selected_input_level_o,
  output wire capture_edge_o
);

  // edge decode by mode, shared by both capture paths
  function edge_hit;
    input [1:0] mode;
    input new_lvl;
    input old_lvl;
    begin
      case (mode)
        `TCCB_EDGE_RISE: edge_hit = new_lvl & ~old_lvl;
        `TCCB_EDGE_FALL: edge_hit = ~new_lvl & old_lvl;
        `TCCB_EDGE_BOTH: edge_hit = new_lvl ^ old_lvl;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  reg [2:0] sa_q; // pin a synchroniser chain
  reg [2:0] sb_q; // pin b synchroniser chain
  reg fa_q; // filtered pin a level
  reg fb_q; // filtered pin b level
  reg sel2_q; // extra stage aligned to timer clock
  reg fa_d;
  reg fb_d;
  reg sel_d;

  // a pin change counts only once stages two and three agree
  always @* begin
    fa_d = (sa_q[2] == sa_q[1]) ? sa_q[1] : fa_q;
    fb_d = (sb_q[2] == sb_q[1]) ? sb_q[1] : fb_q;
    case (input_select_i)
      `TCCB_SEL_A: sel_d = fa_d;
      `TCCB_SEL_B: sel_d = fb_d;
      // fixed levels let software toggle the low select bit to force an edge
      `TCCB_SEL_GND: sel_d = 1'b0;
      default: sel_d = 1'b1;
    endcase
  end

  // synchronisers, filters and level registers
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sa_q <= 3'h0;
      sb_q <= 3'h0;
      fa_q <= 1'b0;
      fb_q <= 1'b0;
      selected_input_level_o <= 1'b0;
      sel2_q <= 1'b0;
    end else begin
      sa_q <= {sa_q[1:0], capture_input_a_i};
      sb_q <= {sb_q[1:0], capture_input_b_i};
      fa_q <= fa_d;
      fb_q <= fb_d;
      selected_input_level_o <= sel_d;
      sel2_q <= selected_input_level_o;
    end
  end

  // synced path waits one timer clock so count and capture never race
  assign capture_edge_o = sync_capture_select_i ?
    edge_hit(edge_mode_bits_i, selected_input_level_o, sel2_q) :
    edge_hit(edge_mode_bits_i, sel_d, selected_input_level_o);

endmodule

// [rtl/tccb_cmp.v]
`timescale 1ns/1ns
`include "tccb_defs.vh"

module tccb_cmp #(
  parameter IS_PERIOD = 0
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // timer side
  input wire [15:0] timer_count_i,
  input wire count_moved_i,
  input wire zero_evt_i,
  input wire top_evt_i,
  // buffered compare data and load choice
  input wire [15:0] ccr_i,
  input wire [1:0] latch_load_select_i,
  // results
  output reg [15:0] compare_latch_o,
  output reg match_o,
  output wire equal_evt_o
);

  wire eq = (timer_count_i == compare_latch_o);
  wire ge = (timer_count_i >= compare_latch_o);
  reg load;

  // pick the transfer event into the latch
  always @* begin
    case (latch_load_select_i)
      `TCCB_LOAD_IMM: load = 1'b1;
      `TCCB_LOAD_ZERO: load = zero_evt_i;
      `TCCB_LOAD_ZERO_TOP: load = zero_evt_i | top_evt_i;
      `TCCB_LOAD_OWN: load = count_moved_i & eq;
      default: load = 1'b0;
    endcase
  end

  // only the latch is ever compared, never the software register
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      compare_latch_o <= `TCCB_LATCH_RST;
      match_o <= 1'b0;
    end else begin
      if (load) begin
        compare_latch_o <= ccr_i;
      end
      match_o <= (IS_PERIOD != 0) ? ge : eq;
    end
  end

  // flag event only when the count arrives, not while it sits stopped
  assign equal_evt_o = count_moved_i & eq;

endmodule

// [rtl/tccb_top.v]
`timescale 1ns/1ns
`include "tccb_defs.vh"

module tccb_top (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // shared timer counter
  input wire [15:0] timer_count_i,
  input wire timer_updown_i,
  // capture sources, one bit per channel
  input wire [6:0] capture_input_a_i,
  input wire [6:0] capture_input_b_i,
  // channel control word fields, one slice per channel, plus the global irq enable bit
  input wire [6:0] capture_select_i,
  input wire [13:0] edge_mode_bits_i,
  input wire [13:0] input_select_i,
  input wire [6:0] sync_capture_select_i,
  input wire [13:0] latch_load_select_i,
  input wire [6:0] block_irq_enable_i,
  input wire global_irq_enable_i,
  // software access to capture_compare_reg and flags
  input wire [6:0] ccr_wr_i,
  input wire [15:0] ccr_wdata_i,
  input wire [6:0] ccr_rd_i,
  input wire [6:0] flag_clr_i,
  input wire [6:0] overrun_clr_i,
  // channel state
  output wire [111:0] capture_compare_reg_o,
  output wire [6:0] block_event_flag_o,
  output wire [6:0] capture_overrun_flag_o,
  output wire [6:0] selected_input_level_o,
  // toward the output units
  output wire [6:0] match_pulse_o,
  output wire period_match_o,
  // interrupt requests
  output wire [6:0] irq_o
);

  // reset release through two flops; assertion stays asynchronous
  reg [1:0] rst_sync_q;
  wire rst_n;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // previous count, to see the timer arrive at a value
  reg [15:0] cnt_prev_q;
  wire count_moved;
  wire zero_evt;
  wire top_evt;
  wire [15:0] period_latch; // channel zero latch, the timer period

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_prev_q <= 16'h0000;
    end else begin
      cnt_prev_q <= timer_count_i;
    end
  end

  // a stopped timer produces no arrival events
  assign count_moved = (timer_count_i != cnt_prev_q);
  assign zero_evt = count_moved & (timer_count_i == 16'h0000);
  // the top turn only counts as a load point in up/down mode
  assign top_evt = count_moved & timer_updown_i & (timer_count_i == period_latch);

  // per-channel arrays
  reg [15:0] ccr_q [0:6]; // capture_compare_reg storage
  reg [6:0] flag_q; // block_event_flag
  reg [6:0] ovr_q; // capture_overrun_flag
  reg [6:0] unread_q; // captured value not yet read
  wire [6:0] cap_edge;
  wire [6:0] cmp_evt;
  wire [6:0] match;
  wire [15:0] latch [0:6];

  genvar i;
  generate
    for (i = 0; i < 7; i = i + 1) begin : g_ch

      // event gating by mode
      wire cap_evt;
      wire cmp_set;

      // input selection, synchronisation and edge detection
      tccb_capsel u_capsel (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .capture_input_a_i(capture_input_a_i[i]),
        .capture_input_b_i(capture_input_b_i[i]),
        .input_select_i(input_select_i[2*i+1:2*i]),
        .sync_capture_select_i(sync_capture_select_i[i]),
        .edge_mode_bits_i(edge_mode_bits_i[2*i+1:2*i]),
        .selected_input_level_o(selected_input_level_o[i]),
        .capture_edge_o(cap_edge[i])
      );

      // compare latch and match logic; channel zero compares >=
      tccb_cmp #(
        .IS_PERIOD(i == 0 ? 1 : 0)
      ) u_cmp (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .timer_count_i(timer_count_i),
        .count_moved_i(count_moved),
        .zero_evt_i(zero_evt),
        .top_evt_i(top_evt),
        .ccr_i(ccr_q[i]),
        .latch_load_select_i(latch_load_select_i[2*i+1:2*i]),
        .compare_latch_o(latch[i]),
        .match_o(match[i]),
        .equal_evt_o(cmp_evt[i])
      );

      // capture only in capture mode; compare events only in compare mode
      assign cap_evt = capture_select_i[i] & cap_edge[i];
      assign cmp_set = ~capture_select_i[i] & cmp_evt[i];

      // software write and capture share the register; capture wins
      always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          ccr_q[i] <= `TCCB_CCR_RST;
        end else if (cap_evt) begin
          ccr_q[i] <= timer_count_i;
        end else if (ccr_wr_i[i]) begin
          ccr_q[i] <= ccr_wdata_i;
        end
      end

      // event flag: set on capture or compare; set beats clear
      always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          flag_q[i] <= 1'b0;
        end else if (cap_evt | cmp_set) begin
          flag_q[i] <= 1'b1;
        end else if (flag_clr_i[i]) begin
          flag_q[i] <= 1'b0;
        end
      end

      // unread tracker, only alive in capture mode
      always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          unread_q[i] <= 1'b0;
        end else if (cap_evt) begin
          unread_q[i] <= 1'b1;
        end else if (ccr_rd_i[i] | ~capture_select_i[i]) begin
          unread_q[i] <= 1'b0;
        end
      end

      // overrun: second capture before a read; only software clears it
      always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          ovr_q[i] <= 1'b0;
        end else if (cap_evt & unread_q[i] & ~ccr_rd_i[i]) begin
          ovr_q[i] <= 1'b1;
        end else if (overrun_clr_i[i]) begin
          ovr_q[i] <= 1'b0;
        end
      end

      // a read in the capture cycle consumes the old value, so no overrun

      assign capture_compare_reg_o[16*i+15:16*i] = ccr_q[i];
      // both enables gate the request; the flag is set regardless
      assign irq_o[i] = flag_q[i] & block_irq_enable_i[i] & global_irq_enable_i;
      assign match_pulse_o[i] = match[i];
    end
  endgenerate

  // software capture: toggling low select with vcc/gnd makes an edge
  // that the both-edge mode turns into exactly one capture
  // stop/restart order of capture versus timer is left to software

  assign period_latch = latch[0];
  assign period_match_o = match[0];
  assign block_event_flag_o = flag_q;
  assign capture_overrun_flag_o = ovr_q;

endmodule

// [dv/tccb_timer_model.sv]
`timescale 1ns/1ns
module tccb_timer_model (
  // clock, reset, control from the bench
  input wire clk_i,
  input wire rst_n_i,
  input wire run_i,
  input wire load_i,
  input wire [15:0] load_val_i,
  // shared count toward the channels
  output logic [15:0] timer_count_o
);
  // halted counter holds, so captures see one known value
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) timer_count_o <= 16'h0000;
    else if (load_i) timer_count_o <= load_val_i;
    else if (run_i) timer_count_o <= timer_count_o + 16'h0001;
  end
endmodule

// [dv/tccb_chk_sva.sv]
`timescale 1ns/1ns
module tccb_chk (
  // every port of the top, seen as inputs
  input wire clk_i, reset_n_i, timer_updown_i, global_irq_enable_i, period_match_o,
  input wire [15:0] timer_count_i, ccr_wdata_i,
  input wire [6:0] capture_input_a_i, capture_input_b_i, capture_select_i,
  input wire [6:0] sync_capture_select_i, block_irq_enable_i, ccr_wr_i, ccr_rd_i,
  input wire [6:0] flag_clr_i, overrun_clr_i, block_event_flag_o, capture_overrun_flag_o,
  input wire [6:0] selected_input_level_o, match_pulse_o, irq_o,
  input wire [13:0] edge_mode_bits_i, input_select_i, latch_load_select_i,
  input wire [111:0] capture_compare_reg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // software capture: supply/ground flip with both edges armed
  sequence sw_flip_s;
    capture_select_i[0] && edge_mode_bits_i[1:0] == 2'h3 && input_select_i[1]
      && $changed(input_select_i[0]) && !block_event_flag_o[0];
  endsequence
  irq_gate_a:
    assert property (irq_o == (block_event_flag_o & block_irq_enable_i
      & {7{global_irq_enable_i}})) else $error("irq gating wrong");
  period_tie_a:
    assert property (period_match_o == match_pulse_o[0]) else $error("period match");
  ovr_sticky_a:
    assert property (capture_overrun_flag_o[1] && !overrun_clr_i[1]
      |=> capture_overrun_flag_o[1]) else $error("overrun dropped");
  cmp_no_ovr_a:
    assert property ((!capture_select_i[1])[*6] |-> !$rose(capture_overrun_flag_o[1]))
      else $error("overrun in compare mode");
  vcc_level_a:
    assert property ((input_select_i[1:0] == 2'h3)[*5] |-> selected_input_level_o[0])
      else $error("supply level");
  gnd_level_a:
    assert property ((input_select_i[1:0] == 2'h2)[*5] |-> !selected_input_level_o[0])
      else $error("ground level");
  sw_cap_a:
    assert property (sw_flip_s |-> ##[1:3] block_event_flag_o[0]) else $error("sw capture");
  cap_value_a:
    assert property ($rose(block_event_flag_o[1]) && capture_select_i[1]
      && $past(capture_select_i[1]) |-> capture_compare_reg_o[31:16]
      == $past(timer_count_i)) else $error("captured count");
  cmp_flag_a:
    assert property ($rose(block_event_flag_o[2]) && !capture_select_i[2]
      && latch_load_select_i[5:4] == 2'h0
      && $past(capture_compare_reg_o[47:32], 2) == capture_compare_reg_o[47:32]
      |-> $past(timer_count_i)
      == capture_compare_reg_o[47:32]) else $error("compare flag");
  // immediate load: latch follows a settled register one edge later
  period_ge_a:
    assert property ($past(reset_n_i, 2) && $past(latch_load_select_i[1:0]) == 2'h0
      && $stable(capture_compare_reg_o[15:0]) |=> period_match_o
      == ($past(timer_count_i) >= $past(capture_compare_reg_o[15:0])))
      else $error("period compare");
endmodule
bind tccb_top tccb_chk tccb_chk_inst (.*);

// [dv/tccb_top_tb.sv]
`timescale 1ns/1ns
module tccb_top_tb;
  logic clk_i = 0, reset_n_i = 0, global_irq_enable = 0, updown = 0, run = 0, ld = 0;
  logic [15:0] ldv = 0, wdata = 0, v;
  logic [6:0] pa = 0, pb = 0, capsel = 0, sync = 0, ie = 0, wr = 0, rd = 0, fclr = 0, oclr = 0;
  logic [13:0] edge_m = 0, isel = 0, lsel = 0;
  wire [15:0] cnt;
  wire [111:0] ccr;
  wire [6:0] flag, ovr, lvl, mp, irq;
  wire pm;
  integer failures = 0, compares = 0, seed = 32'hd9793fcc, i;
  always #5 clk_i = ~clk_i;
  tccb_timer_model tccb_timer_model_inst (.clk_i(clk_i), .rst_n_i(reset_n_i), .run_i(run),
    .load_i(ld), .load_val_i(ldv), .timer_count_o(cnt));
  tccb_top tccb_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .timer_count_i(cnt),
    .timer_updown_i(updown), .capture_input_a_i(pa), .capture_input_b_i(pb),
    .capture_select_i(capsel), .edge_mode_bits_i(edge_m), .input_select_i(isel),
    .sync_capture_select_i(sync), .latch_load_select_i(lsel), .block_irq_enable_i(ie),
    .global_irq_enable_i(global_irq_enable), .ccr_wr_i(wr), .ccr_wdata_i(wdata), .ccr_rd_i(rd),
    .flag_clr_i(fclr), .overrun_clr_i(oclr), .capture_compare_reg_o(ccr),
    .block_event_flag_o(flag), .capture_overrun_flag_o(ovr), .selected_input_level_o(lvl),
    .match_pulse_o(mp), .period_match_o(pm), .irq_o(irq));
  // inputs always move 1 ns after the edge
  task tick(input integer n); repeat (n) @(posedge clk_i); #1; endtask
  task chk(input logic [15:0] g, e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chb(input logic g, e); chk({15'h0, g}, {15'h0, e}); endtask
  task setcnt(input logic [15:0] x); ld = 1; ldv = x; tick(1); ld = 0; endtask
  task wr_ccr(input integer c, input logic [15:0] d);
    wr[c] = 1; wdata = d; tick(1); wr = 0;
  endtask
  // read and clear together, so no stale capture counts as overrun
  task ack(input logic [6:0] c); rd = c; fclr = c; tick(1); rd = 0; fclr = 0; endtask
  function logic expcap(input logic [1:0] m, input logic r);
    return m == 2'h3 || m == (r ? 2'h1 : 2'h2);
  endfunction
  task results;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    tick(6);
    reset_n_i = 1;
    tick(3);
    global_irq_enable = 1; ie = 7'h7f; ack(7'h7f);
    // compare, channel 2, immediate load
    v = $random(seed); v[15:12] = 4'h1;
    wr_ccr(2, v); chk(ccr[47:32], v);
    setcnt(v - 16'h1); tick(2); chb(flag[2] | mp[2], 0);
    setcnt(v); tick(2); chk({13'h0, flag[2], mp[2], irq[2]}, 16'h7);
    global_irq_enable = 0; tick(1); chb(irq[2], 0);
    global_irq_enable = 1; ack(7'h04); tick(2); chb(flag[2], 0);
    setcnt(v + 16'h1); tick(2); chb(mp[2], 0);
    // period match on channel 0 is greater-or-equal
    wr_ccr(0, v); setcnt(v + 16'h5); run = 1; tick(3); run = 0; chb(pm, 1);
    setcnt(v - 16'h1); tick(2); chb(pm, 0);
    // load-on-zero holds the new value back
    lsel[7:6] = 2'h1; wr_ccr(3, v); setcnt(v); tick(2); chb(mp[3], 0);
    setcnt(16'h0); tick(2); setcnt(v); tick(2); chb(mp[3], 1);
    // own-latch arrival, then the top turn in up/down mode
    lsel[7:6] = 2'h3; wr_ccr(3, v + 16'h2); setcnt(v + 16'h2); tick(2); chb(mp[3], 0);
    setcnt(v); tick(1); setcnt(v + 16'h2); tick(2); chb(mp[3], 1);
    lsel[7:6] = 2'h2; updown = 1; wr_ccr(3, v + 16'h4);
    setcnt(v + 16'h4); tick(2); chb(mp[3], 0);
    setcnt(v); tick(1); setcnt(v + 16'h4); tick(2); chb(mp[3], 1); updown = 0;
    $display("compare tests done");
    // timer stays halted before capture is switched on
    // a count passing zero earlier left the compare flag set; clear it first
    capsel[1] = 1; ack(7'h02);
    for (i = 0; i < 16; i++) begin
      edge_m[3:2] = i[3:2]; sync[1] = i[1]; v = $random(seed); setcnt(v); tick(2);
      pa[1] = ~pa[1]; tick(8);
      chb(flag[1], expcap(i[3:2], pa[1]));
      if (expcap(i[3:2], pa[1])) chk(ccr[31:16], v);
      ack(7'h02);
    end
    $display("edge tests done");
    edge_m[3:2] = 2'h3; pa[1] = ~pa[1]; tick(8); pa[1] = ~pa[1]; tick(8);
    chb(ovr[1], 1); tick(20); chb(ovr[1], 1);
    oclr[1] = 1; tick(1); oclr = 0; tick(1); chb(ovr[1], 0);
    ack(7'h02); capsel[1] = 0; tick(2); v = ccr[31:16];
    pa[1] = ~pa[1]; tick(8); pa[1] = ~pa[1]; tick(8);
    chb(ovr[1], 0); chk(ccr[31:16], v);
    isel[3:2] = 2'h1; pb[1] = 1; tick(6); chb(lvl[1], 1);
    isel[3:2] = 2'h0; tick(3); chb(lvl[1], pa[1]);
    $display("overrun tests done");
    // software-started capture on channel 0
    capsel[0] = 1; edge_m[1:0] = 2'h3; isel[1:0] = 2'h2; tick(6); ack(7'h01);
    for (i = 0; i < 4; i++) begin
      v = $random(seed); setcnt(v); isel[0] = ~isel[0]; tick(4);
      chb(flag[0], 1); chk(ccr[15:0], v);
      chb(lvl[0], isel[0]);
      ack(7'h01);
    end
    $display("software capture tests done");
    results;
  end
endmodule
